// File: watch_and_watchdog_timer_tb.sv
// self-checking testbench of the watch and watchdog timer
`timescale 1ns/1ps
module watch_and_watchdog_timer_tb
  import wwdt_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic sub_tick = 1'b0;
  logic main_tick = 1'b0;
  logic stop_mode = 1'b0;
  logic sub_clock_mode = 1'b0;
  logic watch_irq, irq, wake_req, wdog_reset_n, main_osc_on;
  int errors = 0;
  int total_checks = 0;
  logic [7:0] rd, c0;

  wwdt_top i_wwdt_top (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sub_tick(sub_tick), .main_tick(main_tick), .stop_mode(stop_mode),
    .sub_clock_mode(sub_clock_mode), .watch_irq(watch_irq), .irq(irq), .wake_req(wake_req),
    .wdog_reset_n(wdog_reset_n), .main_osc_on(main_osc_on));

  always #20 clk = ~clk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task wrap_up;
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // hold the request until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 100)
    begin
      errors++;
      wrap_up();
    end
  endtask : bus

  // read data is taken at the edge where waitrequest is seen low
  task rd_reg(input logic [9:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rd_reg

  task ticks(input logic use_sub, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (use_sub) sub_tick <= 1'b1; else main_tick <= 1'b1;
      @(posedge clk);
      if (use_sub) sub_tick <= 1'b0; else main_tick <= 1'b0;
    end
    // covers the three-flop pin synchroniser plus the counter step
    repeat (8) @(posedge clk);
  endtask : ticks

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task reg_defaults;
    rd_reg(WWDT_ADDR_WDOG_CTRL);
    check(rd, 8'h18);
    rd_reg(WWDT_ADDR_WATCH_MODE);
    check(rd, 8'h00);
    bus(1'b1, 10'h000, 8'hFF);
    rd_reg(10'h000);
    check(rd, 8'h00);
    bus(1'b1, WWDT_ADDR_WATCH_MODE, 8'hFF);
    rd_reg(WWDT_ADDR_WATCH_MODE);
    check(rd, 8'h4F);
    bus(1'b1, WWDT_ADDR_WATCH_MODE, 8'h00);
    ticks(1'b0, 300);
    rd_reg(WWDT_ADDR_COUNT);
    check(rd, 8'h00);
  endtask : reg_defaults

  task watch_interval;
    // watchdog to interrupt mode so a stray overflow cannot reset the block
    bus(1'b1, WWDT_ADDR_WDOG_CTRL, 8'h10);
    bus(1'b1, WWDT_ADDR_IRQ_MASK, 8'h01);
    // undivided source, used here only as a factory-style fast test
    bus(1'b1, WWDT_ADDR_WATCH_MODE, 8'h4A);
    ticks(1'b0, 1000);
    check({6'h00, watch_irq, irq}, 8'h00);
    ticks(1'b0, 60);
    check({5'h00, wake_req, watch_irq, irq}, 8'h07);
    bus(1'b1, WWDT_ADDR_IRQ_STATUS, 8'h01);
    @(posedge clk);
    #1 check({7'h00, irq}, 8'h00);
    bus(1'b1, WWDT_ADDR_IRQ_MASK, 8'h00);
    ticks(1'b0, 1024);
    rd_reg(WWDT_ADDR_IRQ_STATUS);
    check(rd & 8'h01, 8'h01);
    check({7'h00, irq}, 8'h00);
    bus(1'b1, WWDT_ADDR_IRQ_MASK, 8'h01);
    @(posedge clk);
    #1 check({7'h00, irq}, 8'h01);
    bus(1'b1, WWDT_ADDR_IRQ_STATUS, 8'h01);
  endtask : watch_interval

  task stop_gating;
    stop_mode <= 1'b1;
    rd_reg(WWDT_ADDR_COUNT);
    c0 = rd;
    ticks(1'b0, 200);
    rd_reg(WWDT_ADDR_COUNT);
    check(rd, c0);
    bus(1'b1, WWDT_ADDR_WATCH_MODE, 8'h42);
    ticks(1'b1, 200);
    rd_reg(WWDT_ADDR_COUNT);
    check({7'h00, rd != c0}, 8'h01);
    stop_mode <= 1'b0;
    bus(1'b1, WWDT_ADDR_WATCH_MODE, 8'h4A);
  endtask : stop_gating

  task wdog_match_clear;
    int k;
    k = 0;
    rd = 8'h00;
    while (rd[1:0] == 2'h0 && k < 80)
    begin
      ticks(1'b0, 256);
      rd_reg(WWDT_ADDR_WDOG_CTRL);
      k++;
    end
    check(rd, 8'h11);
    rd_reg(WWDT_ADDR_COUNT);
    check({7'h00, rd < 8'h08}, 8'h01);
    bus(1'b1, WWDT_ADDR_WDOG_CTRL, 8'h30);
    rd_reg(WWDT_ADDR_WDOG_CTRL);
    check(rd, 8'h10);
    rd_reg(WWDT_ADDR_COUNT);
    check({7'h00, rd < 8'h08}, 8'h01);
    check({7'h00, wdog_reset_n}, 8'h01);
    check({7'h00, main_osc_on}, 8'h00);
  endtask : wdog_match_clear

  // ---------------------------------------------------------------
  // main sequence and hang limit
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    reg_defaults();
    watch_interval();
    stop_gating();
    wdog_match_clear();
    wrap_up();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule : watch_and_watchdog_timer_tb

// File: wwdt_pkg.sv
// package: constants, register map and types of the watch and watchdog timer
package wwdt_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [9:0] WWDT_ADDR_WDOG_CTRL = 10'h0DF;
  localparam logic [9:0] WWDT_ADDR_WATCH_MODE = 10'h0EF;
  localparam logic [9:0] WWDT_ADDR_IRQ_STATUS = 10'h0F0;
  localparam logic [9:0] WWDT_ADDR_IRQ_MASK = 10'h0F1;
  localparam logic [9:0] WWDT_ADDR_COUNT = 10'h0F2;

  // watch mode fields
  localparam int WWDT_WM_INTV_LSB = 0;
  localparam int WWDT_WM_CSEL_LSB = 2;
  localparam int WWDT_WM_EN_BIT = 6;
  localparam logic [7:0] WWDT_WM_MASK = 8'h4F;

  // watchdog control fields
  localparam int WWDT_WD_CLR_BIT = 5;
  localparam int WWDT_WD_EN_BIT = 4;
  localparam int WWDT_WD_OMODE_BIT = 3;
  localparam logic [7:0] WWDT_WD_RESET = 8'h18;

  // status / mask bit positions
  localparam int WWDT_ST_WATCH = 0;
  localparam int WWDT_ST_WDOG = 1;

  // source codes
  localparam logic [1:0] WWDT_SRC_SUB = 2'h0;
  localparam logic [1:0] WWDT_SRC_DIV = 2'h1;
  localparam logic [1:0] WWDT_SRC_MAIN = 2'h2;

  localparam logic [6:0] WWDT_DIV_LAST = 7'h7F;
  localparam logic [13:0] WWDT_CNT_LAST = 14'h3FFF;
  localparam logic [1:0] WWDT_WD_LAST = 2'h3;

  typedef struct packed {
    logic [1:0] intv;
    logic [1:0] csel;
    logic en;
  } wwdt_mode_t;

  typedef struct packed {
    logic en;
    logic omode;
  } wwdt_wdctl_t;

endpackage : wwdt_pkg

// File: wwdt_top.sv
// watch timer with 2-bit watchdog behind an avalon-mm slave
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sub_tick,
  input wire logic main_tick,
  input wire logic stop_mode,
  input wire logic sub_clock_mode,
  output logic watch_irq,
  output logic irq,
  output logic wake_req,
  output logic wdog_reset_n,
  output logic main_osc_on
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sub_sync_reg;
  logic [2:0] main_sync_reg;
  logic stop_s1_reg;
  logic stop_reg;
  logic subm_s1_reg;
  logic subm_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sub_sync_reg <= 3'h0;
      main_sync_reg <= 3'h0;
      stop_s1_reg <= 1'b0;
      stop_reg <= 1'b0;
      subm_s1_reg <= 1'b0;
      subm_reg <= 1'b0;
    end
    else
    begin
      sub_sync_reg <= {sub_sync_reg[1:0], sub_tick};
      main_sync_reg <= {main_sync_reg[1:0], main_tick};
      stop_s1_reg <= stop_mode;
      stop_reg <= stop_s1_reg;
      subm_s1_reg <= sub_clock_mode;
      subm_reg <= subm_s1_reg;
    end
  end

  // rising edges, taken from stages 2 and 3 only
  logic sub_edge;
  logic main_edge;
  assign sub_edge = sub_sync_reg[1] & ~sub_sync_reg[2];
  assign main_edge = main_sync_reg[1] & ~main_sync_reg[2];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  wwdt_mode_t mode_reg;
  wwdt_wdctl_t wdctl_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [6:0] div_reg;
  logic [13:0] cnt_reg;
  logic [1:0] wd_cnt_reg;
  logic wd_fire_reg;

  logic wr_mode;
  logic wr_wdctl;
  logic wr_status;
  logic wr_mask;
  logic wd_clear;
  assign wr_mode = avs_write && avs_address == WWDT_ADDR_WATCH_MODE;
  assign wr_wdctl = avs_write && avs_address == WWDT_ADDR_WDOG_CTRL;
  assign wr_status = avs_write && avs_address == WWDT_ADDR_IRQ_STATUS;
  assign wr_mask = avs_write && avs_address == WWDT_ADDR_IRQ_MASK;
  // strobe only, nothing stores it
  assign wd_clear = wr_wdctl && avs_writedata[WWDT_WD_CLR_BIT];

  // ---------------------------------------------------------------
  // read handshake
  // ---------------------------------------------------------------
  // reads hold one wait state so registered data stands when
  // waitrequest drops; writes never wait
  logic rd_done_reg;
  logic rd_take;
  assign rd_take = avs_read && !rd_done_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_done_reg <= 1'b0;
    else
      rd_done_reg <= rd_take;
  end

  assign avs_waitrequest = rd_take;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_reg <= '0;
      mask_reg <= 2'h0;
    end
    else
    begin
      if (wr_mode)
      begin
        mode_reg.intv <= avs_writedata[WWDT_WM_INTV_LSB +: 2];
        mode_reg.csel <= avs_writedata[WWDT_WM_CSEL_LSB +: 2];
        mode_reg.en <= avs_writedata[WWDT_WM_EN_BIT];
      end
      if (wr_mask)
        mask_reg <= avs_writedata[1:0];
    end
  end

  // enable resets to one with reset output chosen
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wdctl_reg.en <= WWDT_WD_RESET[WWDT_WD_EN_BIT];
      wdctl_reg.omode <= WWDT_WD_RESET[WWDT_WD_OMODE_BIT];
    end
    else if (wr_wdctl)
    begin
      wdctl_reg.en <= avs_writedata[WWDT_WD_EN_BIT];
      wdctl_reg.omode <= avs_writedata[WWDT_WD_OMODE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // clock source and counters
  // ---------------------------------------------------------------
  // main clock stops in stop mode, so main-derived ticks are gated
  logic main_ok;
  logic src_tick;
  logic div_tick;
  assign main_ok = main_edge && !stop_reg;
  assign div_tick = main_ok && div_reg == WWDT_DIV_LAST;

  always_comb
  begin
    case (mode_reg.csel)
      WWDT_SRC_SUB: src_tick = sub_edge;
      WWDT_SRC_DIV: src_tick = div_tick;
      // test-only selection, left usable
      WWDT_SRC_MAIN: src_tick = main_ok;
      default: src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      div_reg <= 7'h0;
    else if (main_ok)
      div_reg <= div_reg + 7'h1;
  end

  logic cnt_step;
  assign cnt_step = src_tick && mode_reg.en;

  // free running: no software path clears it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_reg <= 14'h0;
    else if (cnt_step)
      cnt_reg <= cnt_reg + 14'h1;
  end

  // interval taps: 0 -> bit 13, 1 -> bit 11, 2 -> bit 9, 3 -> bit 13
  function automatic logic tap_hit(input logic [13:0] c, input logic [1:0] sel);
    case (sel)
      2'h1: tap_hit = c[11:0] == 12'hFFF;
      2'h2: tap_hit = c[9:0] == 10'h3FF;
      default: tap_hit = c == WWDT_CNT_LAST;
    endcase
  endfunction : tap_hit

  logic watch_event;
  logic match_event;
  assign watch_event = cnt_step && tap_hit(cnt_reg, mode_reg.intv);
  assign match_event = cnt_step && cnt_reg == WWDT_CNT_LAST;

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  logic wd_run;
  logic wd_over;
  assign wd_run = wdctl_reg.en && mode_reg.en;
  assign wd_over = wd_run && match_event && wd_cnt_reg == WWDT_WD_LAST;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wd_cnt_reg <= 2'h0;
    else if (wd_clear)
      wd_cnt_reg <= 2'h0;
    else if (wd_run && match_event)
      wd_cnt_reg <= wd_cnt_reg + 2'h1;
  end

  // one-cycle reset pulse; mode one drives reset, zero raises flag
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wd_fire_reg <= 1'b0;
    else
      wd_fire_reg <= wd_over && wdctl_reg.omode;
  end

  assign wdog_reset_n = ~wd_fire_reg;

  // main oscillator pulsed on for one cycle by a watchdog reset in sub-clock mode
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      main_osc_on <= 1'b0;
    else if (wd_over && wdctl_reg.omode && subm_reg)
      main_osc_on <= 1'b1;
    else
      main_osc_on <= 1'b0;
  end

  // ---------------------------------------------------------------
  // interrupts: set wins over write-one-clear
  // ---------------------------------------------------------------
  logic [1:0] set_bits;
  assign set_bits = {wd_over && !wdctl_reg.omode, watch_event};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      status_reg <= 2'h0;
    else
      status_reg <= (status_reg & ~(wr_status ? avs_writedata[1:0] : 2'h0)) | set_bits;
  end

  assign irq = |(status_reg & mask_reg);
  assign watch_irq = status_reg[WWDT_ST_WATCH] & mask_reg[WWDT_ST_WATCH];
  // stop release only when enabled before
  assign wake_req = watch_irq;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      avs_readdata <= 8'h0;
    else if (rd_take)
    begin
      case (avs_address)
        WWDT_ADDR_WATCH_MODE: avs_readdata <= {1'b0, mode_reg.en, 2'h0, mode_reg.csel, mode_reg.intv};
        WWDT_ADDR_WDOG_CTRL: avs_readdata <= {3'h0, wdctl_reg.en, wdctl_reg.omode, 1'b0, wd_cnt_reg};
        WWDT_ADDR_IRQ_STATUS: avs_readdata <= {6'h0, status_reg};
        WWDT_ADDR_IRQ_MASK: avs_readdata <= {6'h0, mask_reg};
        WWDT_ADDR_COUNT: avs_readdata <= cnt_reg[13:6];
        default: avs_readdata <= 8'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_CLEAR_ZEROES: assert property (wd_clear |=> wd_cnt_reg == 2'h0)
    else $error("watchdog count not cleared");
  AST_NO_CLOCK_WITHOUT_EN: assert property (!mode_reg.en |=> $stable(cnt_reg))
    else $error("counter moved while disabled");
  AST_COUNT_STEP: assert property (cnt_step |=> cnt_reg == $past(cnt_reg) + 14'h1)
    else $error("counter did not step");
  AST_WD_STEP: assert property (wd_run && match_event && !wd_clear && wd_cnt_reg != WWDT_WD_LAST
    |=> wd_cnt_reg == $past(wd_cnt_reg) + 2'h1)
    else $error("watchdog did not step on match");
  AST_RESET_PULSE: assert property (wd_over && wdctl_reg.omode |=> !wdog_reset_n ##1 wdog_reset_n)
    else $error("watchdog reset pulse wrong");
  AST_FLAG_SET: assert property (wd_over && !wdctl_reg.omode |=> status_reg[WWDT_ST_WDOG] && wdog_reset_n)
    else $error("watchdog flag not set");
  AST_DISABLED_QUIET: assert property (!wd_run && !wd_clear |=> $stable(wd_cnt_reg))
    else $error("watchdog moved while disabled");
  AST_STOP_MAIN: assert property (stop_reg && mode_reg.csel != WWDT_SRC_SUB |-> !cnt_step)
    else $error("main source counted in stop");
  AST_OSC_ON: assert property (wd_over && wdctl_reg.omode && subm_reg |=> main_osc_on)
    else $error("main oscillator not turned on");
  AST_WATCH_SET: assert property (watch_event |=> status_reg[WWDT_ST_WATCH])
    else $error("watch flag not set");

  COV_WATCH: cover property (watch_event);
  COV_WD_RESET: cover property (!wdog_reset_n);
  COV_WD_IRQ: cover property (set_bits[WWDT_ST_WDOG]);
  COV_CLEAR: cover property (wd_clear && wd_cnt_reg != 2'h0);
  COV_STOP_SUB: cover property (stop_reg && cnt_step);

  AST_READ_ONE_WAIT: assert property (
    avs_read && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("read wait state too long");

  AST_MODE_WRITE: assert property (
    wr_mode
    |=> mode_reg.en == $past(avs_writedata[WWDT_WM_EN_BIT]))
    else $error("mode enable not written");

  AST_CLR_NOT_STORED: assert property (
    avs_read && !avs_waitrequest && avs_address == WWDT_ADDR_WDOG_CTRL
    |-> !avs_readdata[WWDT_WD_CLR_BIT])
    else $error("clear bit reads back set");

  AST_NO_SW_CLEAR: assert property (
    !cnt_step
    |=> $stable(cnt_reg))
    else $error("counter moved without a step");

  AST_DIV_SRC: assert property (
    mode_reg.en && mode_reg.csel == WWDT_SRC_DIV
    |-> cnt_step == div_tick)
    else $error("divided source not used");

  AST_SUB_SRC: assert property (
    mode_reg.en && mode_reg.csel == WWDT_SRC_SUB
    |-> cnt_step == sub_edge)
    else $error("sub source not counted");

  AST_STATUS_STICKY: assert property (
    status_reg[WWDT_ST_WATCH] && !(wr_status && avs_writedata[WWDT_ST_WATCH])
    |=> status_reg[WWDT_ST_WATCH])
    else $error("watch flag lost without clear");

  AST_WAKE_FROM_STOP: assert property (
    stop_reg && status_reg[WWDT_ST_WATCH] && mask_reg[WWDT_ST_WATCH]
    |-> wake_req)
    else $error("no wake request in stop");

  AST_WD_WRAP: assert property (
    wd_over && !wd_clear
    |=> wd_cnt_reg == 2'h0)
    else $error("watchdog count did not wrap");

  AST_RESET_IDLE: assert property (
    !(wd_over && wdctl_reg.omode)
    |=> wdog_reset_n)
    else $error("reset pulse without overflow");

  AST_OSC_IDLE: assert property (
    !(wd_over && wdctl_reg.omode && subm_reg)
    |=> !main_osc_on)
    else $error("oscillator pulse without cause");

  AST_IRQ_MASKED: assert property (
    (status_reg & mask_reg) == 2'h0
    |-> !irq)
    else $error("masked interrupt raised");

  AST_NO_FLAG_IN_RESET_MODE: assert property (
    wd_over && wdctl_reg.omode && !status_reg[WWDT_ST_WDOG] && !set_bits[WWDT_ST_WDOG]
    |=> !status_reg[WWDT_ST_WDOG])
    else $error("flag set in reset mode");

  AST_RESET_NEEDS_EN: assert property (
    !wd_run
    |-> !wd_over)
    else $error("overflow while watchdog unclocked");

endmodule : wwdt_top
